// file: shared/irq_gate_consts.svh
// address map, bit positions and reset values of the interrupt gate block
`ifndef IRQ_GATE_CONSTS_SVH
`define IRQ_GATE_CONSTS_SVH

// ----------------------------------------------------------------------
// special-function addresses and pages
// ----------------------------------------------------------------------
`define ADDR_ENABLE_PRIMARY   8'ha8
`define ADDR_PRIORITY_PRIMARY 8'hb8
`define ADDR_ENABLE_EXT_FIRST 8'he6
`define PAGE_PRIORITY_PRIMARY 8'h00

// ----------------------------------------------------------------------
// bit positions
// ----------------------------------------------------------------------
`define BIT_GLOBAL_GATE       3'd7
`define BIT_PRIORITY_UNUSED   3'd7
`define BIT_TIMER_TWO_MASK    3'd5
`define BIT_TIMER_THREE_MASK  3'd7

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_ENABLE_PRIMARY    8'h00
`define RST_PRIORITY_PRIMARY  8'h80
`define RST_ENABLE_EXT_FIRST  8'h00
`define RST_VECTOR_INDEX      4'h0

// ----------------------------------------------------------------------
// source count
// ----------------------------------------------------------------------
`define SOURCE_COUNT          15

`endif

// file: shared/irq_gate_pkg.sv
// types shared by the interrupt gate block
package irq_gate_pkg;

	// one register-port access from the core
	typedef struct packed {
		logic       wr;
		logic       bit_wr;
		logic [7:0] addr;
		logic [7:0] page;
		logic [2:0] bit_sel;
		logic [7:0] wdata;
	} sfr_access_s;

	// raw request flags from the peripherals
	typedef struct packed {
		logic two_wire;
		logic rtc_alarm;
		logic window_compare_flag;
		logic conversion_done_flag;
		logic counter_array;
		logic comparator_a_rise_flag;
		logic comparator_a_fall_flag;
		logic comparator_b_rise_flag;
		logic comparator_b_fall_flag;
		logic timer_three_low_overflow;
		logic timer_three_high_overflow;
		logic ext_input_a;
		logic timer_zero_overflow;
		logic ext_input_b;
		logic timer_one_overflow;
		logic async_port;
		logic timer_two_low_overflow;
		logic timer_two_high_overflow;
		logic serial_periph_a;
	} irq_sources_s;

	// request presented to the core
	typedef struct packed {
		logic       valid;
		logic       high_level;
		logic [3:0] index;
	} irq_request_s;

endpackage : irq_gate_pkg

// file: src/irq_gate.sv
// interrupt enable and priority registers with request selection
// How it works
// - global gate bit 7 clear blocks every source whatever the masks say
// - with global gate set, a source passes only when its own mask is set
// - primary enable bit 6 gates the serial peripheral unit requests
// - primary enable bit 5 gates timer two; low or high overflow requests
// - primary enable bit 4 gates the asynchronous serial port requests
// - primary enable bit 3 gates the timer one overflow request
// - primary enable bit 2 gates the second external input
// - primary enable bit 1 gates the timer zero overflow request
// - primary enable bit 0 gates the first external input
// - primary enable sits at 0xa8 on all pages, bit-addressable
// - priority bit 7 always reads one and ignores writes
// - priority bits 6..0 pick high or low level per source
// - priority register at 0xb8 on page zero only, bit-addressable
// - first extended enable sits at 0xe6 on all pages
// - extended bit 7 gates timer three; low or high overflow requests
// - extended bits 6 and 5 gate comparator b and a edge flags
// - extended bit 4 gates the counter array requests
// - extended bit 3 gates the conversion-done flag
// - extended bit 2 gates the window-compare flag
// - extended bit 1 gates the clock alarm request
// - extended bit 0 gates the two-wire bus unit requests
`timescale 1ns/1ps
`default_nettype none
`include "irq_gate_consts.svh"

module irq_gate #(
	parameter int SOURCES = `SOURCE_COUNT
) (
	input  wire logic                      mclk,
	input  wire logic                      srst,
	input  wire irq_gate_pkg::sfr_access_s sfr,
	output logic [7:0]                     sfr_rdata,
	output logic                           sfr_hit,
	input  wire irq_gate_pkg::irq_sources_s src,
	output irq_gate_pkg::irq_request_s     req,
	output logic                           global_irq_gate
);

	// ------------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------------
	if (SOURCES != `SOURCE_COUNT) begin : g_bad_sources
		$error("irq_gate serves exactly the fixed source set");
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic [7:0] enable_primary_reg;
	logic [7:0] priority_primary_reg;
	logic [7:0] enable_ext_first_reg;
	logic [7:0] enable_primary_next;
	logic [7:0] priority_primary_next;
	logic [7:0] enable_ext_first_next;
	logic       hit_enp;
	logic       hit_pri;
	logic       hit_ext;

	assign hit_enp = sfr.addr == `ADDR_ENABLE_PRIMARY;
	assign hit_pri = sfr.addr == `ADDR_PRIORITY_PRIMARY
		&& sfr.page == `PAGE_PRIORITY_PRIMARY;
	assign hit_ext = sfr.addr == `ADDR_ENABLE_EXT_FIRST;
	assign sfr_hit = hit_enp | hit_pri | hit_ext;

	// bit writes touch one bit; the rest keep their value
	function automatic logic [7:0] merge(input logic [7:0] cur,
		input irq_gate_pkg::sfr_access_s a);
		logic [7:0] v;
		v = cur;
		if (a.bit_wr) begin
			v[a.bit_sel] = a.wdata[0];
		end else begin
			v = a.wdata;
		end
		return v;
	endfunction : merge

	always_comb begin
		enable_primary_next   = enable_primary_reg;
		priority_primary_next = priority_primary_reg;
		enable_ext_first_next = enable_ext_first_reg;
		if (sfr.wr && hit_enp) begin
			enable_primary_next = merge(enable_primary_reg, sfr);
		end
		if (sfr.wr && hit_pri) begin
			priority_primary_next = merge(priority_primary_reg, sfr);
		end
		if (sfr.wr && hit_ext) begin
			enable_ext_first_next = merge(enable_ext_first_reg, sfr);
		end
		// unused priority bit is held at one whatever is written
		priority_primary_next[`BIT_PRIORITY_UNUSED] = 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			enable_primary_reg <= `RST_ENABLE_PRIMARY;
		end else begin
			enable_primary_reg <= enable_primary_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			priority_primary_reg <= `RST_PRIORITY_PRIMARY;
		end else begin
			priority_primary_reg <= priority_primary_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			enable_ext_first_reg <= `RST_ENABLE_EXT_FIRST;
		end else begin
			enable_ext_first_reg <= enable_ext_first_next;
		end
	end

	always_comb begin
		sfr_rdata = 8'h00;
		if (hit_enp) begin
			sfr_rdata = enable_primary_reg;
		end else if (hit_pri) begin
			sfr_rdata = priority_primary_reg;
		end else if (hit_ext) begin
			sfr_rdata = enable_ext_first_reg;
		end
	end

	assign global_irq_gate = enable_primary_reg[`BIT_GLOBAL_GATE];

	// ------------------------------------------------------------------
	// per-source requests, index is the fixed source order
	// ------------------------------------------------------------------
	logic [14:0] raw;
	logic [14:0] mask;
	logic [14:0] level;
	logic [14:0] gated;

	always_comb begin
		raw[0]  = src.ext_input_a;
		raw[1]  = src.timer_zero_overflow;
		raw[2]  = src.ext_input_b;
		raw[3]  = src.timer_one_overflow;
		raw[4]  = src.async_port;
		raw[5]  = src.timer_two_low_overflow
			| src.timer_two_high_overflow;
		raw[6]  = src.serial_periph_a;
		raw[7]  = src.two_wire;
		raw[8]  = src.rtc_alarm;
		raw[9]  = src.window_compare_flag;
		raw[10] = src.conversion_done_flag;
		raw[11] = src.counter_array;
		raw[12] = src.comparator_a_rise_flag
			| src.comparator_a_fall_flag;
		raw[13] = src.comparator_b_rise_flag
			| src.comparator_b_fall_flag;
		raw[14] = src.timer_three_low_overflow
			| src.timer_three_high_overflow;
	end

	// primary bits 6..0 map straight to sources 6..0; extended
	// bits 0..7 map to sources 7..14
	always_comb begin
		mask[6:0] = enable_primary_reg[6:0];
		for (int i = 0; i < 8; i++) begin
			mask[7 + i] = enable_ext_first_reg[i];
		end
		level[6:0]  = priority_primary_reg[6:0];
		// extended priority register is not held here: low level
		level[14:7] = 8'h00;
	end

	assign gated = global_irq_gate ? (raw & mask) : 15'h0000;

	// ------------------------------------------------------------------
	// selection; registered so the core sees a clean request
	// ------------------------------------------------------------------
	logic [14:0] hi_pend;
	logic [14:0] pend_set;
	logic        pick_hi;
	logic [3:0]  pick_idx;
	irq_gate_pkg::irq_request_s req_reg;

	assign hi_pend  = gated & level;
	assign pick_hi  = |hi_pend;
	assign pend_set = pick_hi ? hi_pend : gated;

	always_comb begin
		pick_idx = `RST_VECTOR_INDEX;
		for (int i = 14; i >= 0; i--) begin
			if (pend_set[i]) begin
				pick_idx = 4'(i);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			req_reg <= '0;
		end else begin
			req_reg.valid      <= |gated;
			req_reg.high_level <= pick_hi;
			req_reg.index      <= pick_idx;
		end
	end

	assign req = req_reg;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	property p_global_off;
		@(posedge mclk) disable iff (srst)
		!global_irq_gate |=> !req.valid;
	endproperty
	a_global_off: assert property (p_global_off)
		else $error("request passed with global gate off");

	property p_masked_pass;
		@(posedge mclk) disable iff (srst)
		(global_irq_gate && (raw & mask) != 15'h0000)
			|=> req.valid;
	endproperty
	a_masked_pass: assert property (p_masked_pass)
		else $error("enabled source was not forwarded");

	property p_timer_two;
		@(posedge mclk) disable iff (srst)
		(global_irq_gate && enable_primary_reg[`BIT_TIMER_TWO_MASK]
			&& src.timer_two_high_overflow) |=> req.valid;
	endproperty
	a_timer_two: assert property (p_timer_two)
		else $error("timer two high overflow not forwarded");

	property p_timer_three;
		@(posedge mclk) disable iff (srst)
		(global_irq_gate && !enable_ext_first_reg[`BIT_TIMER_THREE_MASK]
			&& raw == 15'h4000) |=> !req.valid;
	endproperty
	a_timer_three: assert property (p_timer_three)
		else $error("masked timer three request forwarded");

	property p_unused_one;
		@(posedge mclk) disable iff (srst)
		priority_primary_reg[7];
	endproperty
	a_unused_one: assert property (p_unused_one)
		else $error("unused priority bit read as zero");

	property p_pri_page;
		@(posedge mclk) disable iff (srst)
		(sfr.wr && sfr.addr == `ADDR_PRIORITY_PRIMARY
			&& sfr.page != `PAGE_PRIORITY_PRIMARY)
			|=> $stable(priority_primary_reg);
	endproperty
	a_pri_page: assert property (p_pri_page)
		else $error("priority written from wrong page");

	property p_enp_write;
		@(posedge mclk) disable iff (srst)
		(sfr.wr && !sfr.bit_wr && sfr.addr == `ADDR_ENABLE_PRIMARY)
			|=> enable_primary_reg == $past(sfr.wdata);
	endproperty
	a_enp_write: assert property (p_enp_write)
		else $error("primary enable write lost");

	property p_ext_write;
		@(posedge mclk) disable iff (srst)
		(sfr.wr && !sfr.bit_wr && sfr.addr == `ADDR_ENABLE_EXT_FIRST)
			|=> enable_ext_first_reg == $past(sfr.wdata);
	endproperty
	a_ext_write: assert property (p_ext_write)
		else $error("extended enable write lost");

	property p_high_first;
		@(posedge mclk) disable iff (srst)
		(gated[0] && gated[6] && level[6] && !level[0]
			&& hi_pend[5:1] == 5'h00)
			|=> req.index == 4'h6 && req.high_level;
	endproperty
	a_high_first: assert property (p_high_first)
		else $error("low level served before high level");

	property p_order;
		@(posedge mclk) disable iff (srst)
		(gated[1] && gated[3] && !gated[0]
			&& level[1] == level[3] && !pick_hi)
			|=> req.index == 4'h1;
	endproperty
	a_order: assert property (p_order)
		else $error("fixed order broken at equal level");

	// a request trails its cause by one edge, which is why the request checks use |=>
	property p_enp_bit;
		@(posedge mclk) disable iff (srst)
		(sfr.wr && sfr.bit_wr && hit_enp)
			|=> enable_primary_reg[$past(sfr.bit_sel)]
				== $past(sfr.wdata[0]);
	endproperty
	a_enp_bit: assert property (p_enp_bit)
		else $error("primary enable bit write lost");

	property p_pri_bit;
		@(posedge mclk) disable iff (srst)
		(sfr.wr && sfr.bit_wr && hit_pri
			&& sfr.bit_sel != `BIT_PRIORITY_UNUSED)
			|=> priority_primary_reg[$past(sfr.bit_sel)]
				== $past(sfr.wdata[0]);
	endproperty
	a_pri_bit: assert property (p_pri_bit)
		else $error("priority bit write lost");

	// unmapped reads give zero so a stray read never looks like a mask
	property p_unmapped;
		@(posedge mclk) disable iff (srst)
		!sfr_hit |-> sfr_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped address returned data");

	property p_high_level;
		@(posedge mclk) disable iff (srst)
		(gated & level) != 15'h0000 |=> req.valid && req.high_level;
	endproperty
	a_high_level: assert property (p_high_level)
		else $error("high level request shown as low");

	property p_low_level;
		@(posedge mclk) disable iff (srst)
		(gated != 15'h0000 && (gated & level) == 15'h0000)
			|=> req.valid && !req.high_level;
	endproperty
	a_low_level: assert property (p_low_level)
		else $error("low level request shown as high");

	property p_masked_block;
		@(posedge mclk) disable iff (srst)
		(global_irq_gate && raw != 15'h0000 && (raw & mask) == 15'h0000)
			|=> !req.valid;
	endproperty
	a_masked_block: assert property (p_masked_block)
		else $error("masked source was forwarded");

	c_high: cover property (@(posedge mclk) req.valid && req.high_level);
	c_low: cover property (@(posedge mclk) req.valid && !req.high_level);
	c_ext: cover property (@(posedge mclk) req.valid && req.index == 4'he);
	c_bit: cover property (@(posedge mclk) sfr.wr && sfr.bit_wr && hit_enp);
	c_order: cover property (@(posedge mclk) req.valid && req.index == 4'h1);

endmodule : irq_gate
`default_nettype wire

// file: dv/src_bank.sv
// peripheral flag bank standing in for the request sources
`timescale 1ns/1ps
`default_nettype none

module src_bank (
	input  wire logic                  mclk,
	input  wire logic                  srst,
	input  wire logic [18:0]           set_vec,
	input  wire logic                  clr,
	output irq_gate_pkg::irq_sources_s src
);
	// flags stay up until the core side clears them, like real peripherals
	always_ff @(posedge mclk) begin
		if (srst || clr) begin
			src <= '0;
		end else begin
			src <= irq_gate_pkg::irq_sources_s'(src | set_vec);
		end
	end
endmodule : src_bank

`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the interrupt gate block
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic                       mclk;
	logic                       srst;
	irq_gate_pkg::sfr_access_s  sfr;
	logic [7:0]                 sfr_rdata;
	logic                       sfr_hit;
	irq_gate_pkg::irq_sources_s src;
	irq_gate_pkg::irq_request_s req;
	logic                       global_irq_gate;
	logic [18:0]                set_vec;
	logic                       clr;
	int                         fails;
	int                         comparisons;
	// source index served by each raw flag, lowest struct bit first
	int idx_of [19] = '{6, 5, 5, 4, 3, 2, 1, 0, 14, 14, 13, 13, 12, 12,
		11, 10, 9, 8, 7};
	logic [14:0]                m;

	irq_gate dut (.mclk(mclk), .srst(srst), .sfr(sfr), .sfr_rdata(sfr_rdata),
		.sfr_hit(sfr_hit), .src(src), .req(req),
		.global_irq_gate(global_irq_gate));
	src_bank peers (.mclk(mclk), .srst(srst), .set_vec(set_vec), .clr(clr),
		.src(src));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task put(input logic bw, input logic [7:0] a, input logic [7:0] p,
		input logic [2:0] b, input logic [7:0] d);
		@(posedge mclk);
		sfr <= '{1'b1, bw, a, p, b, d};
		@(posedge mclk);
		sfr <= '{1'b0, 1'b0, a, p, 3'h0, 8'h00};
	endtask : put

	task rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] exp,
		input logic hit);
		@(posedge mclk);
		sfr <= '{1'b0, 1'b0, a, p, 3'h0, 8'h00};
		#1;
		chk("sfr_rdata", exp, sfr_rdata);
		chk("sfr_hit", {7'h00, hit}, {7'h00, sfr_hit});
	endtask : rd

	task raise(input logic [18:0] v);
		@(posedge mclk);
		set_vec <= v;
		@(posedge mclk);
		set_vec <= 19'h00000;
	endtask : raise

	task drop();
		@(posedge mclk);
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
	endtask : drop

	// flag lands one edge after set, request one edge after that
	task req_chk(input logic v, input logic h, input logic [3:0] idx);
		repeat (3) @(posedge mclk);
		#1;
		chk("req", {2'h0, v, h, idx}, {2'h0, req});
	endtask : req_chk

	task wrap_up();
		if (fails == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		srst = 1'b1;
		sfr = '0;
		set_vec = 19'h00000;
		clr = 1'b0;
		fails = 0;
		comparisons = 0;
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		rd(8'ha8, 8'h00, 8'h00, 1'b1);
		rd(8'hb8, 8'h00, 8'h80, 1'b1);
		rd(8'he6, 8'h05, 8'h00, 1'b1);
		rd(8'h99, 8'h00, 8'h00, 1'b0);
		for (int i = 0; i < 19; i++) begin
			m = 15'h0001 << idx_of[i];
			put(1'b0, 8'ha8, 8'h0f, 3'h0, {1'b0, m[6:0]});
			put(1'b0, 8'he6, 8'h0f, 3'h0, m[14:7]);
			raise(19'h00001 << i);
			req_chk(1'b0, 1'b0, 4'h0);
			chk("global_irq_gate", 8'h00, {7'h00, global_irq_gate});
			put(1'b0, 8'ha8, 8'h02, 3'h0, {1'b1, ~m[6:0]});
			put(1'b0, 8'he6, 8'h02, 3'h0, ~m[14:7]);
			req_chk(1'b0, 1'b0, 4'h0);
			put(1'b0, 8'ha8, 8'h00, 3'h0, {1'b1, m[6:0]});
			put(1'b0, 8'he6, 8'h00, 3'h0, m[14:7]);
			req_chk(1'b1, 1'b0, 4'(idx_of[i]));
			drop();
		end
		put(1'b0, 8'ha8, 8'h00, 3'h0, 8'hff);
		put(1'b0, 8'he6, 8'h00, 3'h0, 8'hff);
		chk("global_irq_gate", 8'h01, {7'h00, global_irq_gate});
		raise(19'h7ffff);
		req_chk(1'b1, 1'b0, 4'h0);
		for (int k = 0; k < 7; k++) begin
			put(1'b0, 8'hb8, 8'h00, 3'h0, 8'h01 << k);
			req_chk(1'b1, 1'b1, 4'(k));
			rd(8'hb8, 8'h00, 8'h80 | (8'h01 << k), 1'b1);
		end
		put(1'b0, 8'hb8, 8'h01, 3'h0, 8'h00);
		rd(8'hb8, 8'h00, 8'hc0, 1'b1);
		rd(8'hb8, 8'h01, 8'h00, 1'b0);
		put(1'b1, 8'hb8, 8'h00, 3'h7, 8'h00);
		put(1'b1, 8'hb8, 8'h00, 3'h2, 8'h01);
		rd(8'hb8, 8'h00, 8'hc4, 1'b1);
		req_chk(1'b1, 1'b1, 4'h2);
		put(1'b0, 8'hb8, 8'h00, 3'h0, 8'h00);
		rd(8'hb8, 8'h00, 8'h80, 1'b1);
		// first input masked: timer zero must beat timer one at equal level
		put(1'b0, 8'ha8, 8'h00, 3'h0, 8'h8a);
		req_chk(1'b1, 1'b0, 4'h1);
		put(1'b1, 8'ha8, 8'h03, 3'h7, 8'h00);
		rd(8'ha8, 8'h03, 8'h0a, 1'b1);
		req_chk(1'b0, 1'b0, 4'h0);
		// a second reset in mid-run must bring every register back
		@(posedge mclk);
		srst <= 1'b1;
		@(posedge mclk);
		srst <= 1'b0;
		rd(8'ha8, 8'h00, 8'h00, 1'b1);
		rd(8'hb8, 8'h00, 8'h80, 1'b1);
		rd(8'he6, 8'h00, 8'h00, 1'b1);
		req_chk(1'b0, 1'b0, 4'h0);
		chk("global_irq_gate", 8'h00, {7'h00, global_irq_gate});
		wrap_up();
	end

	// the run needs about six hundred cycles; this bound is far above
	initial begin
		#200000;
		fails++;
		wrap_up();
	end
endmodule : testbench

`default_nettype wire
